// [src/pscs_regs.svh]
// Command codes, field positions and timing counts of the supply-pin serial link
`ifndef PSCS_REGS_SVH
`define PSCS_REGS_SVH

// ------------------------------------------------------------------
// Command field encodings
// ------------------------------------------------------------------
`define PSCS_CMD_READ_RESP      8'h73
`define PSCS_CMD_BURST_WRITE    8'hD0
`define PSCS_CMD_BURST_READ     8'hD3
`define PSCS_LOW_WRITE          4'h1
`define PSCS_LOW_READ_INIT      4'h2
`define PSCS_CMD_TYPE_BIT       7
`define PSCS_PAGE_MSB           6
`define PSCS_PAGE_LSB           4

// ------------------------------------------------------------------
// Valid register pages
// ------------------------------------------------------------------
`define PSCS_PAGE_0             3'h0
`define PSCS_PAGE_2             3'h2
`define PSCS_PAGE_5             3'h5

// ------------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------------
`define PSCS_CACHE_BYTES        8
`define PSCS_LAST_BYTE          3'h7
`define PSCS_BYTE_RESET         8'h00

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define PSCS_CLK_MHZ            10
`define PSCS_TURN_TIME_US       20
`define PSCS_TURN_CYCLES        (`PSCS_TURN_TIME_US * `PSCS_CLK_MHZ)
`define PSCS_IDLE_TIME_US       15000
`define PSCS_IDLE_CYCLES        (`PSCS_IDLE_TIME_US * `PSCS_CLK_MHZ)

`endif

// [src/pscs_pkg.sv]
// Types shared by the supply-pin serial link command layer
package pscs_pkg;

    typedef enum logic [3:0] {
        PSCS_IDLE     = 4'h0,
        PSCS_CMD      = 4'h1,
        PSCS_WR_ADDR  = 4'h3,
        PSCS_WR_DATA  = 4'h2,
        PSCS_DISCARD  = 4'h6,
        PSCS_RI_ADDR  = 4'h7,
        PSCS_RI_FETCH = 4'h5,
        PSCS_TURN     = 4'h4,
        PSCS_RR_SEND  = 4'hC,
        PSCS_BW_DATA  = 4'hD,
        PSCS_BR_SEND  = 4'hF
    } pscs_state_e;

    typedef struct packed {
        pscs_state_e     state;
        logic [2:0]      page;
        logic [7:0]      addr;
        logic [7:0]      wdata;
        logic            wr;
        logic            rd;
        logic [7:0]      held;
        logic [7:0][7:0] cache;
        logic [2:0]      idx;
        logic [7:0]      turn_cnt;
        logic [7:0]      tx_byte;
        logic            tx_valid;
        logic [17:0]     idle_cnt;
        logic            line_meta;
        logic            line_sync;
        logic            line_last;
    } pscs_top_s;

endpackage : pscs_pkg

// [src/pscs_fifo_if.sv]
// Drain side of the received-field FIFO
`timescale 1ns/1ps
`default_nettype none

interface pscs_fifo_if;
    logic [8:0] data;
    logic       valid;
    logic       ready;

    modport producer (output data, output valid, input ready);
    modport consumer (input data, input valid, output ready);
endinterface : pscs_fifo_if

`default_nettype wire

// [src/pscs_fifo.sv]
// Synchronous FIFO for received link fields
`timescale 1ns/1ps
`default_nettype none

module pscs_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic       in_valid_in,
    output logic            in_ready_out,
    // Drain side
    pscs_fifo_if.producer   drain
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
        logic                        ready;
    } pscs_fifo_s;

    pscs_fifo_s st_reg;
    pscs_fifo_s st_next;
    logic       push;
    logic       pop;

    always_comb begin
        st_next = st_reg;
        push    = in_valid_in && st_reg.ready;
        pop     = drain.ready && (st_reg.count != '0);
        if (push) begin
            st_next.mem[st_reg.wr_ptr] = in_data_in;
            st_next.wr_ptr             = st_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
        st_next.count = st_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        // Registered ready: full is known one cycle ahead, so no overrun
        st_next.ready = (st_next.count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            st_reg       <= '0;
            st_reg.ready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready_out = st_reg.ready;
    assign drain.valid  = (st_reg.count != '0);
    assign drain.data   = st_reg.mem[st_reg.rd_ptr];

endmodule : pscs_fifo

`default_nettype wire

// [src/pscs_top.sv]
// Command layer of the supply-pin serial link
`include "pscs_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pscs_top #(
    parameter int IDLE_CYCLES = `PSCS_IDLE_CYCLES
) (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    // Raw link line, watched for idle time only
    input  wire logic        link_line_in,
    // Received fields from the field receiver
    input  wire logic [7:0]  rx_byte_in,
    input  wire logic        rx_sync_in,
    input  wire logic        rx_valid_in,
    output logic             rx_ready_out,
    // Fields to the field transmitter
    output logic [7:0]       tx_byte_out,
    output logic             tx_valid_out,
    input  wire logic        tx_ready_in,
    // Register page access
    output logic [2:0]       csr_page_out,
    output logic [7:0]       csr_addr_out,
    output logic [7:0]       csr_wdata_out,
    output logic             csr_wr_out,
    output logic             csr_rd_out,
    input  wire logic [7:0]  csr_rdata_in,
    // Memory cache contents
    output logic [63:0]      cache_out
);
    localparam logic [7:0]  TURN_LAST = 8'(`PSCS_TURN_CYCLES - 1);
    localparam logic [17:0] IDLE_LAST = 18'(IDLE_CYCLES - 1);

    pscs_pkg::pscs_top_s st_reg;
    pscs_pkg::pscs_top_s st_next;
    pscs_fifo_if         rx_q ();
    logic                rx_ready_fifo;
    logic [7:0]          fb;
    logic                fsync;
    logic                take;
    logic                idle_hit;

    // ------------------------------------------------------------------
    // Receive FIFO: sync marker rides in bit 8 so frame starts stay ordered
    // ------------------------------------------------------------------
    pscs_fifo #(
        .WIDTH (9),
        .DEPTH (32)
    ) u_rx_fifo (
        .ref_clk_in   (ref_clk_in),
        .rst_n_in     (rst_n_in),
        .in_data_in   ({rx_sync_in, rx_byte_in}),
        .in_valid_in  (rx_valid_in),
        .in_ready_out (rx_ready_fifo),
        .drain        (rx_q.producer)
    );

    function automatic logic page_ok(input logic [2:0] p);
        page_ok = (p == `PSCS_PAGE_0) || (p == `PSCS_PAGE_2) || (p == `PSCS_PAGE_5);
    endfunction : page_ok

    function automatic logic pops(input pscs_pkg::pscs_state_e s);
        pops = (s != pscs_pkg::PSCS_TURN) && (s != pscs_pkg::PSCS_RR_SEND) &&
               (s != pscs_pkg::PSCS_BR_SEND) && (s != pscs_pkg::PSCS_RI_FETCH);
    endfunction : pops

    // ------------------------------------------------------------------
    // Command decode and field sequencing
    // ------------------------------------------------------------------
    // Stalls the FIFO while transmitting or timing, so back-pressure reaches
    // the field receiver.
    assign rx_q.ready = pops(st_reg.state);

    always_comb begin
        st_next          = st_reg;
        st_next.wr       = 1'b0;
        st_next.rd       = 1'b0;
        fb               = rx_q.data[7:0];
        fsync            = rx_q.data[8];
        take             = rx_q.valid && pops(st_reg.state);
        idle_hit         = 1'b0;

        // Line idle watch, after a two-stage synchroniser
        st_next.line_meta = link_line_in;
        st_next.line_sync = st_reg.line_meta;
        st_next.line_last = st_reg.line_sync;
        if (st_reg.line_sync != st_reg.line_last) begin
            st_next.idle_cnt = '0;
        end else if (st_reg.idle_cnt == IDLE_LAST) begin
            idle_hit         = 1'b1;
            st_next.idle_cnt = '0;
        end else begin
            st_next.idle_cnt = st_reg.idle_cnt + 18'h00001;
        end

        if (take && fsync) begin
            st_next.state = pscs_pkg::PSCS_CMD;
        end else if (take) begin
            case (st_reg.state)
                pscs_pkg::PSCS_CMD: begin
                    st_next.page = fb[`PSCS_PAGE_MSB:`PSCS_PAGE_LSB];
                    st_next.idx  = '0;
                    if (fb == `PSCS_CMD_READ_RESP) begin
                        st_next.turn_cnt = '0;
                        st_next.state    = pscs_pkg::PSCS_TURN;
                    end else if (fb == `PSCS_CMD_BURST_WRITE) begin
                        st_next.state = pscs_pkg::PSCS_BW_DATA;
                    end else if (fb == `PSCS_CMD_BURST_READ) begin
                        st_next.tx_byte  = st_reg.cache[0];
                        st_next.tx_valid = 1'b1;
                        st_next.state    = pscs_pkg::PSCS_BR_SEND;
                    end else if (!fb[`PSCS_CMD_TYPE_BIT] && page_ok(fb[6:4]) &&
                                 fb[3:0] == `PSCS_LOW_WRITE) begin
                        st_next.state = pscs_pkg::PSCS_WR_ADDR;
                    end else if (!fb[`PSCS_CMD_TYPE_BIT] && page_ok(fb[6:4]) &&
                                 fb[3:0] == `PSCS_LOW_READ_INIT) begin
                        st_next.state = pscs_pkg::PSCS_RI_ADDR;
                    end else begin
                        st_next.state = pscs_pkg::PSCS_DISCARD;
                    end
                end
                pscs_pkg::PSCS_WR_ADDR: begin
                    st_next.addr  = fb;
                    st_next.state = pscs_pkg::PSCS_WR_DATA;
                end
                pscs_pkg::PSCS_WR_DATA: begin
                    st_next.wdata = fb;
                    st_next.wr    = 1'b1;
                    st_next.state = pscs_pkg::PSCS_DISCARD;
                end
                pscs_pkg::PSCS_RI_ADDR: begin
                    st_next.addr  = fb;
                    st_next.rd    = 1'b1;
                    st_next.state = pscs_pkg::PSCS_RI_FETCH;
                end
                pscs_pkg::PSCS_BW_DATA: begin
                    // Each byte lands as it arrives; a cut frame leaves the rest
                    st_next.cache[st_reg.idx] = fb;
                    st_next.idx               = st_reg.idx + 3'h1;
                    if (st_reg.idx == `PSCS_LAST_BYTE) begin
                        st_next.state = pscs_pkg::PSCS_DISCARD;
                    end
                end
                default: begin
                    st_next.state = st_reg.state;
                end
            endcase
        end else begin
            case (st_reg.state)
                pscs_pkg::PSCS_RI_FETCH: begin
                    st_next.held  = csr_rdata_in;
                    st_next.state = pscs_pkg::PSCS_DISCARD;
                end
                pscs_pkg::PSCS_TURN: begin
                    st_next.turn_cnt = st_reg.turn_cnt + 8'h01;
                    if (st_reg.turn_cnt == TURN_LAST) begin
                        st_next.tx_byte  = st_reg.held;
                        st_next.tx_valid = 1'b1;
                        st_next.state    = pscs_pkg::PSCS_RR_SEND;
                    end
                end
                pscs_pkg::PSCS_RR_SEND: begin
                    if (tx_ready_in) begin
                        st_next.tx_valid = 1'b0;
                        st_next.state    = pscs_pkg::PSCS_DISCARD;
                    end
                end
                pscs_pkg::PSCS_BR_SEND: begin
                    if (tx_ready_in) begin
                        st_next.idx = st_reg.idx + 3'h1;
                        if (st_reg.idx == `PSCS_LAST_BYTE) begin
                            st_next.tx_valid = 1'b0;
                            st_next.state    = pscs_pkg::PSCS_DISCARD;
                        end else begin
                            st_next.tx_byte = st_reg.cache[st_reg.idx + 3'h1];
                        end
                    end
                end
                default: begin
                    st_next.state = st_reg.state;
                end
            endcase
        end

        // Idle timeout drops the frame; stale fields are skipped until a sync
        if (idle_hit) begin
            st_next.state    = pscs_pkg::PSCS_IDLE;
            st_next.tx_valid = 1'b0;
            st_next.wr       = 1'b0;
            st_next.rd       = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            st_reg       <= '0;
            st_reg.state <= pscs_pkg::PSCS_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign rx_ready_out  = rx_ready_fifo;
    assign tx_byte_out   = st_reg.tx_byte;
    assign tx_valid_out  = st_reg.tx_valid;
    assign csr_page_out  = st_reg.page;
    assign csr_addr_out  = st_reg.addr;
    assign csr_wdata_out = st_reg.wdata;
    assign csr_wr_out    = st_reg.wr;
    assign csr_rd_out    = st_reg.rd;
    assign cache_out     = st_reg.cache;

endmodule : pscs_top

`default_nettype wire

// [tb/pscs_far_model.sv]
// Far-side model: field transmitter sink and register page responder
`timescale 1ns/1ps
`default_nettype none

module pscs_far_model (
    // Clock and test control
    input  wire logic       ref_clk_in,
    input  wire logic       stall_in,
    // Transmit stream
    input  wire logic [7:0] tx_byte_in,
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out,
    // Register page
    input  wire logic [2:0] page_in,
    input  wire logic [7:0] addr_in,
    input  wire logic       rd_in,
    output logic [7:0]      rdata_out
);
    logic [7:0] got_q[$];
    logic [1:0] beat = 2'h0;
    logic [7:0] junk = 8'h00;

    // Slow mode accepts one beat in four to exercise held outputs
    assign tx_ready_out = !stall_in || (beat == 2'h3);
    assign rdata_out    = rd_in ? (addr_in ^ {5'h00, page_in}) : junk;

    always @(posedge ref_clk_in) begin
        beat <= beat + 2'h1;
        // Read data is good only while the strobe is high; otherwise it scrambles
        junk <= ~junk;
        if (tx_valid_in && tx_ready_out) got_q.push_back(tx_byte_in);
    end
endmodule : pscs_far_model

`default_nettype wire

// [tb/pscs_top_checker.sv]
// Assertion checker for the supply-pin link command layer
`timescale 1ns/1ps
`default_nettype none

module pscs_top_checker #(
    parameter int IDLE_CYCLES = 50
) (
    // Watched top-level ports
    input wire logic        ref_clk_in,
    input wire logic        rst_n_in,
    input wire logic        link_line_in,
    input wire logic        tx_valid_out,
    input wire logic        tx_ready_in,
    input wire logic [7:0]  tx_byte_out,
    input wire logic [2:0]  csr_page_out,
    input wire logic        csr_wr_out,
    input wire logic        csr_rd_out,
    input wire logic [63:0] cache_out
);
    logic [17:0] still_reg;
    logic        line_reg;

    always_ff @(posedge ref_clk_in) begin
        line_reg  <= link_line_in;
        still_reg <= (!rst_n_in || link_line_in != line_reg) ? 18'h0 : still_reg + 18'h1;
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_wr_one_pulse: assert property (csr_wr_out |=> !csr_wr_out)
        else $error("register write strobe longer than one cycle");
    a_rd_one_pulse: assert property (csr_rd_out |=> !csr_rd_out)
        else $error("register read strobe longer than one cycle");
    a_wr_page_ok: assert property (csr_wr_out |-> csr_page_out inside {3'h0, 3'h2, 3'h5})
        else $error("write issued to a reserved page");
    a_rd_page_ok: assert property (csr_rd_out |-> csr_page_out inside {3'h0, 3'h2, 3'h5})
        else $error("read issued to a reserved page");
    a_tx_held: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
        else $error("transmit byte dropped or changed before acceptance");
    a_rd_no_send: assert property (csr_rd_out |-> !tx_valid_out [*3])
        else $error("byte sent during read initialization");
    a_cache_quiet: assert property (!$stable(cache_out) |-> !tx_valid_out && !csr_rd_out)
        else $error("cache changed outside a burst write");
    a_idle_clear: assert property (still_reg == 18'(IDLE_CYCLES + 4) |-> !tx_valid_out)
        else $error("transmit still pending after idle line timeout");
endmodule : pscs_top_checker

bind pscs_top pscs_top_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.*);

`default_nettype wire

// [tb/pscs_top_tb_top.sv]
// Self-checking bench for the supply-pin link command layer
`timescale 1ns/1ps
`default_nettype none

module pscs_top_tb_top;
    // Must exceed the 200-cycle turnaround, or the idle watch cuts it short
    localparam int IDLE = 400;
    typedef struct packed { logic [7:0] c; logic w; logic r; } pscs_row_s;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic        line  = 1'b0;
    logic        sync  = 1'b0;
    logic        vld   = 1'b0;
    logic        stall = 1'b0;
    logic [7:0]  rxb   = 8'h00;
    logic [7:0]  txb, wdata, addr, rdata, cp, ca, cd;
    logic [2:0]  page;
    logic [63:0] cache;
    logic        rdy, txv, txr, wr, rd;
    int          mismatches = 0;
    int          tests_run = 0;
    int          nwr = 0;
    int          nrd = 0;
    int          n;
    pscs_row_s   rows [14] = '{'{8'h01, 1'b1, 1'b0}, '{8'h11, 1'b0, 1'b0},
        '{8'h21, 1'b1, 1'b0}, '{8'h31, 1'b0, 1'b0}, '{8'h41, 1'b0, 1'b0},
        '{8'h51, 1'b1, 1'b0}, '{8'h61, 1'b0, 1'b0}, '{8'h71, 1'b0, 1'b0},
        '{8'h02, 1'b0, 1'b1}, '{8'h22, 1'b0, 1'b1}, '{8'h52, 1'b0, 1'b1},
        '{8'h32, 1'b0, 1'b0}, '{8'h05, 1'b0, 1'b0}, '{8'h94, 1'b0, 1'b0}};

    pscs_top #(.IDLE_CYCLES(IDLE)) dut (.ref_clk_in(clk), .rst_n_in(rst_n), .link_line_in(line),
        .rx_byte_in(rxb), .rx_sync_in(sync), .rx_valid_in(vld), .rx_ready_out(rdy),
        .tx_byte_out(txb), .tx_valid_out(txv), .tx_ready_in(txr), .csr_page_out(page),
        .csr_addr_out(addr), .csr_wdata_out(wdata), .csr_wr_out(wr), .csr_rd_out(rd),
        .csr_rdata_in(rdata), .cache_out(cache));
    pscs_far_model pm (.ref_clk_in(clk), .stall_in(stall), .tx_byte_in(txb), .tx_valid_in(txv),
        .tx_ready_out(txr), .page_in(page), .addr_in(addr), .rd_in(rd), .rdata_out(rdata));

    always #50 clk = ~clk;

    always @(posedge clk) begin
        if (wr === 1'b1) begin
            nwr++;
            cp = {5'h00, page};
            ca = addr;
            cd = wdata;
        end
        if (rd === 1'b1) begin
            nrd++;
            cp = {5'h00, page};
            ca = addr;
        end
    end

    // ------
    // Helpers
    // ------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    // Each field toggles the raw line so the idle timer only runs when silent
    task automatic send(input logic s, input logic [7:0] b);
        @(posedge clk);
        #1 vld = 1'b1;
        sync = s;
        rxb = b;
        line = ~line;
        while (rdy !== 1'b1) begin @(posedge clk); #1; end
        @(posedge clk);
        #1 vld = 1'b0;
    endtask : send

    task automatic frm(input logic [7:0] c, input int cnt, input logic [63:0] d);
        send(1'b1, 8'h00);
        send(1'b0, c);
        for (int i = 0; i < cnt; i++) send(1'b0, d[8*i+:8]);
    endtask : frm

    // ------
    // Sequence
    // ------
    initial begin
        #(100 * 20000);
        mismatches++;
        results();
    end

    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        foreach (rows[i]) begin
            nwr = 0;
            nrd = 0;
            frm(rows[i].c, 3, {40'h0, 8'h3C, 8'hA0 + 8'(i), 8'h10 + 8'(i)});
            repeat (12) @(posedge clk);
            check("write count", nwr, rows[i].w);
            check("read count", nrd, rows[i].r);
            if (rows[i].w || rows[i].r) check("page", cp, rows[i].c[6:4]);
            if (rows[i].w || rows[i].r) check("addr", ca, 8'h10 + 8'(i));
            if (rows[i].w) check("wdata", cd, 8'hA0 + 8'(i));
        end
        frm(8'h73, 0, 64'h0);
        n = 0;
        while (txv !== 1'b1 && n < 400) begin @(posedge clk); #1 n++; end
        check("turnaround", n >= 200 && n <= 205, 1'b1);
        check("read data", txb, 8'h1A ^ 8'h05);
        frm(8'hD0, 8, 64'h8877_6655_4433_2211);
        repeat (6) @(posedge clk);
        check("cache", cache, 64'h8877_6655_4433_2211);
        #1 stall = 1'b1;
        pm.got_q.delete();
        frm(8'hD3, 0, 64'h0);
        n = 0;
        while (pm.got_q.size() < 8 && n < 200) begin @(posedge clk); #1 n++; end
        check("burst count", pm.got_q.size(), 8);
        foreach (pm.got_q[k]) check("burst byte", pm.got_q[k], 8'h11 * (k + 1));
        frm(8'hD0, 3, 64'hCC_BBAA);
        send(1'b1, 8'h00);
        repeat (6) @(posedge clk);
        check("short burst", cache, 64'h8877_6655_44CC_BBAA);
        frm(8'h73, 0, 64'h0);
        repeat (4) @(posedge clk);
        for (int k = 0; k < 32; k++) send(1'b0, 8'h5A);
        repeat (3) @(posedge clk);
        check("fifo full", rdy, 1'b0);
        n = 0;
        while (rdy !== 1'b1 && n < 600) begin @(posedge clk); #1 n++; end
        check("fifo drained", rdy, 1'b1);
        stall = 1'b0;
        send(1'b1, 8'h00);
        send(1'b0, 8'h01);
        nwr = 0;
        repeat (IDLE + 10) @(posedge clk);
        send(1'b0, 8'h20);
        send(1'b0, 8'h21);
        repeat (8) @(posedge clk);
        check("idle drop", nwr, 0);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 check("reset cache", cache, 64'h0);
        check("reset ready", rdy, 1'b1);
        check("reset tx", txv, 1'b0);
        rst_n = 1'b1;
        results();
    end
endmodule : pscs_top_tb_top

`default_nettype wire
